// ==== src/cbb_params.svh ====
// constants for the compare and compare-bump-branch execution block
`ifndef CBB_PARAMS_SVH
`define CBB_PARAMS_SVH
// ==================================================================
// opcodes
`define CBB_OP_CMP_RR 8'ha2
`define CBB_OP_CMP_RI 8'ha3
`define CBB_OP_CMP_GG 8'ha4
`define CBB_OP_CMP_GI 8'ha5
`define CBB_OP_CMP_IM 8'ha6
`define CBB_OP_CBB 8'hc2
// ==================================================================
// byte lengths
`define CBB_LEN_2 2'h2
`define CBB_LEN_3 2'h3
// ==================================================================
// cycle counts
`define CBB_CYC_4 5'h04
`define CBB_CYC_6 5'h06
`define CBB_CYC_TAKEN 5'h12
`define CBB_CYC_NOT_TAKEN 5'h10
// ==================================================================
// flag positions in the flag byte
`define CBB_FLAG_C 7
`define CBB_FLAG_Z 6
`define CBB_FLAG_S 5
`define CBB_FLAG_V 4
`endif

// ==== src/cbb_pkg.sv ====
// types for the compare and compare-bump-branch execution block
package cbb_pkg;
    // ==============================================================
    // source addressing modes
    typedef enum logic [2:0] {
        CBB_SRC_NONE = 3'h0,
        CBB_SRC_REG = 3'h1,
        CBB_SRC_IND = 3'h2,
        CBB_SRC_IMM = 3'h3
    } cbb_src_mode_t;
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        CBB_IDLE = 3'b001,
        CBB_BUSY = 3'b010,
        CBB_DONE = 3'b100
    } cbb_state_t;
endpackage

// ==== src/cbb_alu.sv ====
// subtract unit producing difference and compare flags
`timescale 1ns/1ps
`default_nettype none
module cbb_alu #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] minuend,
    input wire logic [WIDTH-1:0] subtrahend,
    output logic [WIDTH-1:0] diff,
    output logic borrow,
    output logic zero,
    output logic negative,
    output logic overflow
);
    // ==============================================================
    // elaboration check
    if (WIDTH < 2) begin : g_bad
        $error("cbb_alu: WIDTH must be at least 2");
    end
    // ==============================================================
    // subtraction with an extra bit to catch the borrow
    logic [WIDTH:0] wide;
    always_comb begin
        wide = {1'b0, minuend} - {1'b0, subtrahend};
        diff = wide[WIDTH-1:0];
        borrow = wide[WIDTH];
        zero = (diff == '0);
        negative = diff[WIDTH-1];
        // signed overflow: operand signs differ and result sign flips
        overflow = (minuend[WIDTH-1] != subtrahend[WIDTH-1]) &&
                   (diff[WIDTH-1] != minuend[WIDTH-1]);
    end
endmodule
`default_nettype wire

// ==== src/cbb_exec.sv ====
// execution sequencer for compare and compare-bump-branch-on-equal
`timescale 1ns/1ps
`default_nettype none
`include "cbb_params.svh"
module cbb_exec #(
    parameter int PC_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start, // one-cycle pulse from decoder
    input wire logic [7:0] opcode,
    input wire logic [7:0] dst_value, // destination operand
    input wire logic [7:0] src_value, // fetched source operand
    input wire logic [7:0] src_pointer, // current indirect pointer
    input wire logic [7:0] relative_branch_offset,
    input wire logic [PC_WIDTH-1:0] program_counter, // next-instr pc
    input wire logic [7:0] flags_in,
    output logic busy,
    output logic done, // one-cycle pulse at the end
    output logic illegal, // pulse: opcode not handled here
    output logic [1:0] byte_len,
    output logic [4:0] cycle_count,
    output cbb_pkg::cbb_src_mode_t src_mode,
    output logic flags_we,
    output logic [7:0] flags_out,
    output logic pointer_we,
    output logic [7:0] indirect_source_pointer,
    output logic pc_we,
    output logic [PC_WIDTH-1:0] pc_out
);
    import cbb_pkg::*;
    // ==============================================================
    // elaboration check
    if (PC_WIDTH < 8) begin : g_bad
        $error("cbb_exec: PC_WIDTH must be at least 8");
    end
    // ==============================================================
    // decode helpers
    // true for every flag-compare variant
    function automatic logic is_cmp(input logic [7:0] op);
        is_cmp = (op == `CBB_OP_CMP_RR) || (op == `CBB_OP_CMP_RI) ||
                 (op == `CBB_OP_CMP_GG) || (op == `CBB_OP_CMP_GI) ||
                 (op == `CBB_OP_CMP_IM);
    endfunction
    // length in bytes per variant
    function automatic logic [1:0] len_of(input logic [7:0] op);
        len_of = (op == `CBB_OP_CMP_RR || op == `CBB_OP_CMP_RI) ?
                 `CBB_LEN_2 : `CBB_LEN_3;
    endfunction
    // ==============================================================
    // subtract unit shared by both instructions
    logic [7:0] diff;
    logic borrow;
    logic zero;
    logic negative;
    logic overflow;
    cbb_alu #(.WIDTH(8)) u_alu (
        .minuend(dst_value),
        .subtrahend(src_value),
        .diff(diff),
        .borrow(borrow),
        .zero(zero),
        .negative(negative),
        .overflow(overflow)
    );
    // ==============================================================
    // state
    cbb_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d; // cycles left in the instruction
    logic op_cbb_q, op_cbb_d; // latched: bump-branch in flight
    logic taken_q, taken_d; // latched compare outcome
    logic [7:0] flags_hold_q, flags_hold_d; // computed flag byte
    logic [PC_WIDTH-1:0] target_q, target_d; // branch target
    logic [7:0] ptr_next_q, ptr_next_d; // bumped pointer
    // registered outputs
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic illegal_q, illegal_d;
    logic [1:0] len_q, len_d;
    logic [4:0] cyc_q, cyc_d;
    cbb_src_mode_t mode_q, mode_d;
    logic flags_we_q, flags_we_d;
    logic [7:0] flags_out_q, flags_out_d;
    logic ptr_we_q, ptr_we_d;
    logic [7:0] ptr_q, ptr_d;
    logic pc_we_q, pc_we_d;
    logic [PC_WIDTH-1:0] pc_q, pc_d;
    // sign-extended offset
    logic [PC_WIDTH-1:0] offset_ext;
    assign offset_ext = {{(PC_WIDTH-8){relative_branch_offset[7]}},
                         relative_branch_offset};
    // ==============================================================
    // next-state logic
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        op_cbb_d = op_cbb_q;
        taken_d = taken_q;
        flags_hold_d = flags_hold_q;
        target_d = target_q;
        ptr_next_d = ptr_next_q;
        busy_d = busy_q;
        done_d = 1'b0;
        illegal_d = 1'b0;
        len_d = len_q;
        cyc_d = cyc_q;
        mode_d = mode_q;
        flags_we_d = 1'b0;
        flags_out_d = flags_out_q;
        ptr_we_d = 1'b0;
        ptr_d = ptr_q;
        pc_we_d = 1'b0;
        pc_d = pc_q;
        case (state_q)
            CBB_IDLE: begin
                if (start && is_cmp(opcode)) begin
                    // flags from the difference, operands untouched
                    op_cbb_d = 1'b0;
                    flags_hold_d = flags_in;
                    flags_hold_d[`CBB_FLAG_C] = borrow;
                    flags_hold_d[`CBB_FLAG_Z] = zero;
                    flags_hold_d[`CBB_FLAG_S] = negative;
                    flags_hold_d[`CBB_FLAG_V] = overflow;
                    len_d = len_of(opcode);
                    cyc_d = (opcode == `CBB_OP_CMP_RR) ?
                            `CBB_CYC_4 : `CBB_CYC_6;
                    case (opcode)
                        `CBB_OP_CMP_RI: mode_d = CBB_SRC_IND;
                        `CBB_OP_CMP_GI: mode_d = CBB_SRC_IND;
                        `CBB_OP_CMP_IM: mode_d = CBB_SRC_IMM;
                        default: mode_d = CBB_SRC_REG;
                    endcase
                    cnt_d = cyc_d - 5'h01;
                    busy_d = 1'b1;
                    state_d = CBB_BUSY;
                end else if (start && opcode == `CBB_OP_CBB) begin
                    op_cbb_d = 1'b1;
                    taken_d = zero;
                    target_d = program_counter + offset_ext;
                    ptr_next_d = src_pointer + 8'h01;
                    len_d = `CBB_LEN_3;
                    mode_d = CBB_SRC_IND;
                    cyc_d = zero ? `CBB_CYC_TAKEN :
                            `CBB_CYC_NOT_TAKEN;
                    cnt_d = cyc_d - 5'h01;
                    busy_d = 1'b1;
                    state_d = CBB_BUSY;
                end else if (start) begin
                    // not one of ours: flag it and stay idle
                    illegal_d = 1'b1;
                end
            end
            CBB_BUSY: begin
                // count out the documented cycle budget
                if (cnt_q == 5'h01) begin
                    state_d = CBB_DONE;
                    if (op_cbb_q) begin
                        // pointer lands before the next instruction
                        ptr_we_d = 1'b1;
                        ptr_d = ptr_next_q;
                        pc_we_d = taken_q;
                        pc_d = taken_q ? target_q : pc_q;
                        flags_we_d = 1'b0;
                    end else begin
                        // only the flag byte is written
                        flags_we_d = 1'b1;
                        flags_out_d = flags_hold_q;
                    end
                end
                cnt_d = cnt_q - 5'h01;
            end
            CBB_DONE: begin
                // final cycle: the writes above are now visible
                done_d = 1'b1;
                busy_d = 1'b0;
                cnt_d = 5'h00;
                state_d = CBB_IDLE;
            end
            default: begin
                state_d = CBB_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end
    // ==============================================================
    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= CBB_IDLE;
            cnt_q <= 5'h00;
            op_cbb_q <= 1'b0;
            taken_q <= 1'b0;
            flags_hold_q <= 8'h00;
            target_q <= '0;
            ptr_next_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            illegal_q <= 1'b0;
            len_q <= 2'h0;
            cyc_q <= 5'h00;
            mode_q <= CBB_SRC_NONE;
            flags_we_q <= 1'b0;
            flags_out_q <= 8'h00;
            ptr_we_q <= 1'b0;
            ptr_q <= 8'h00;
            pc_we_q <= 1'b0;
            pc_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            op_cbb_q <= op_cbb_d;
            taken_q <= taken_d;
            flags_hold_q <= flags_hold_d;
            target_q <= target_d;
            ptr_next_q <= ptr_next_d;
            busy_q <= busy_d;
            done_q <= done_d;
            illegal_q <= illegal_d;
            len_q <= len_d;
            cyc_q <= cyc_d;
            mode_q <= mode_d;
            flags_we_q <= flags_we_d;
            flags_out_q <= flags_out_d;
            ptr_we_q <= ptr_we_d;
            ptr_q <= ptr_d;
            pc_we_q <= pc_we_d;
            pc_q <= pc_d;
        end
    end
    // ==============================================================
    // outputs straight from flops
    assign busy = busy_q;
    assign done = done_q;
    assign illegal = illegal_q;
    assign byte_len = len_q;
    assign cycle_count = cyc_q;
    assign src_mode = mode_q;
    assign flags_we = flags_we_q;
    assign flags_out = flags_out_q;
    assign pointer_we = ptr_we_q;
    assign indirect_source_pointer = ptr_q;
    assign pc_we = pc_we_q;
    assign pc_out = pc_q;
endmodule
`default_nettype wire

// ==== dv/cbb_exec_chk.sv ====
// assertion checker for the compare execution block
`timescale 1ns/1ps
`default_nettype none
module cbb_exec_chk #(
    parameter int PC_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] dst_value,
    input wire logic [7:0] src_value,
    input wire logic [7:0] src_pointer,
    input wire logic [7:0] relative_branch_offset,
    input wire logic [PC_WIDTH-1:0] program_counter,
    input wire logic busy,
    input wire logic done,
    input wire logic [4:0] cycle_count,
    input wire logic flags_we,
    input wire logic [7:0] flags_out,
    input wire logic pointer_we,
    input wire logic [7:0] indirect_source_pointer,
    input wire logic pc_we,
    input wire logic [PC_WIDTH-1:0] pc_out
);
    // ==========================================================
    // operand capture
    logic take; // request accepted this edge
    logic [7:0] d_q, s_q, p_q, o_q;
    logic [PC_WIDTH-1:0] pc_q;
    logic [7:0] df; // reference difference
    // idle again in the done cycle, so only busy blocks a start
    assign take = start && !busy;
    assign df = d_q - s_q;
    // inputs only count at the accepting edge
    always_ff @(posedge clk) begin
        if (take) begin
            d_q <= dst_value;
            s_q <= src_value;
            p_q <= src_pointer;
            o_q <= relative_branch_offset;
            pc_q <= program_counter;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // properties
    cmp_short_a: assert property (take && opcode == 8'ha2 |->
        ##4 flags_we ##1 done) else $error("short compare timing");
    cmp_long_a: assert property (take && opcode inside {[8'ha3:8'ha6]}
        |=> cycle_count == 5'h06 ##5 flags_we ##1 done)
        else $error("long compare timing");
    cmp_only_flags_a: assert property (flags_we |-> !pointer_we && !pc_we)
        else $error("compare wrote an operand");
    carry_sign_a: assert property (flags_we |->
        flags_out[7] == (d_q < s_q) && flags_out[5] == df[7])
        else $error("carry or sign flag");
    zero_flag_a: assert property (flags_we |-> flags_out[6] == (df == 8'h00))
        else $error("zero flag");
    branch_eq_a: assert property (take && opcode == 8'hc2 &&
        dst_value == src_value |-> ##18 pc_we && pointer_we ##1 done)
        else $error("taken branch timing");
    fall_thru_a: assert property (take && opcode == 8'hc2 &&
        dst_value != src_value |-> ##16 pointer_we && !pc_we ##1 done)
        else $error("untaken branch timing");
    ptr_bump_a: assert property (pointer_we |->
        indirect_source_pointer == p_q + 8'h01 && !flags_we)
        else $error("pointer bump");
    pc_target_a: assert property (pc_we |->
        pc_out == pc_q + {{(PC_WIDTH-8){o_q[7]}}, o_q})
        else $error("branch target");
    cover property (take && opcode == 8'ha2);
    cover property (pc_we);
    cover property (pointer_we && !pc_we);
endmodule
bind cbb_exec cbb_exec_chk #(.PC_WIDTH(PC_WIDTH)) i_chk (.clk, .rst_n,
    .start, .opcode, .dst_value, .src_value, .src_pointer,
    .relative_branch_offset, .program_counter, .busy, .done, .cycle_count,
    .flags_we, .flags_out, .pointer_we, .indirect_source_pointer, .pc_we,
    .pc_out);
`default_nettype wire

// ==== dv/cbb_core_model.sv ====
// core model holding flag byte, source pointer and program counter
`timescale 1ns/1ps
`default_nettype none
module cbb_core_model #(
    parameter int PC_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flags_we,
    input wire logic [7:0] flags_wr,
    input wire logic pointer_we,
    input wire logic [7:0] pointer_wr,
    input wire logic pc_we,
    input wire logic [PC_WIDTH-1:0] pc_wr,
    output logic [7:0] flags,
    output logic [7:0] pointer,
    output logic [PC_WIDTH-1:0] pc
);
    // ==========================================================
    // state only moves on a strobe, so stray writes show up
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags <= 8'h00;
            pointer <= 8'h00;
            pc <= '0;
        end else begin
            if (flags_we) begin
                flags <= flags_wr;
            end
            if (pointer_we) begin
                pointer <= pointer_wr;
            end
            if (pc_we) begin
                pc <= pc_wr;
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/compare_and_compare_branch_tb.sv ====
// self-checking bench for the compare execution block
`timescale 1ns/1ps
`default_nettype none
module compare_and_compare_branch_tb;
    // ==========================================================
    // signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic [7:0] opcode = 8'h00, dst_value = 8'h00, src_value = 8'h00;
    logic [7:0] offset = 8'h00, flags_out, isp, flags, ptr;
    logic [15:0] pc, pc_out, e_pc;
    logic busy, done, illegal, flags_we, pointer_we, pc_we;
    logic [7:0] e_flags, e_ptr;
    logic [1:0] blen; // instruction length seen
    logic [2:0] smode; // source mode seen
    logic [4:0] ccount; // cycle budget seen
    int mismatches = 0, samples_checked = 0, seed, i, k;
    logic [7:0] ops [6] = '{8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'hc2};
    always #10 clk = ~clk;
    cbb_exec i_dut (.clk(clk), .rst_n(rst_n), .start(start),
        .opcode(opcode), .dst_value(dst_value), .src_value(src_value),
        .src_pointer(ptr), .relative_branch_offset(offset),
        .program_counter(pc), .flags_in(flags), .busy(busy), .done(done),
        .illegal(illegal), .byte_len(blen), .cycle_count(ccount),
        .src_mode(smode),
        .flags_we(flags_we), .flags_out(flags_out),
        .pointer_we(pointer_we), .indirect_source_pointer(isp),
        .pc_we(pc_we), .pc_out(pc_out));
    cbb_core_model i_core (.clk(clk), .rst_n(rst_n), .flags_we(flags_we),
        .flags_wr(flags_out), .pointer_we(pointer_we), .pointer_wr(isp),
        .pc_we(pc_we), .pc_wr(pc_out), .flags(flags), .pointer(ptr),
        .pc(pc));
    // ==========================================================
    // helpers
    task automatic chk(input string name, input logic [15:0] e,
        input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s exp %h got %h", name, e, g);
        end
    endtask
    // documented budget per opcode and outcome
    function automatic logic [15:0] exp_cyc(input logic [7:0] op,
        input logic [7:0] r);
        if (op == 8'hc2) begin
            exp_cyc = (r == 8'h00) ? 16'h0012 : 16'h0010;
        end else begin
            exp_cyc = (op == 8'ha2) ? 16'h0004 : 16'h0006;
        end
    endfunction
    // a2 (register) and a3 (indirect) are short, the rest carry an extra byte
    function automatic logic [15:0] exp_len(input logic [7:0] op);
        exp_len = (op == 8'ha2 || op == 8'ha3) ? 16'h0002 : 16'h0003;
    endfunction
    // source mode: 1 register, 2 indirect, 3 immediate
    function automatic logic [15:0] exp_mode(input logic [7:0] op);
        case (op)
            8'ha3, 8'ha5, 8'hc2: exp_mode = 16'h0002;
            8'ha6: exp_mode = 16'h0003;
            default: exp_mode = 16'h0001;
        endcase
    endfunction
    // one instruction; a stray start lands while busy and must be ignored
    task automatic run(input logic [7:0] op, d, s, o);
        int n;
        int b;
        logic [7:0] r;
        n = 0;
        b = 0;
        r = d - s;
        @(negedge clk);
        opcode = op;
        dst_value = d;
        src_value = s;
        offset = o;
        start = 1'b1;
        while (n < 30 && done !== 1'b1) begin
            @(negedge clk);
            n++;
            if (busy === 1'b1) begin
                b++;
            end
            start = (n == 2);
        end
        if (op == 8'hc2) begin
            e_ptr = e_ptr + 8'h01;
            if (r == 8'h00) e_pc = e_pc + {{8{o[7]}}, o};
        end else begin
            e_flags = {d < s, r == 8'h00, r[7],
                (d[7] != s[7]) && (r[7] != d[7]), e_flags[3:0]};
        end
        // busy spans the budget, done comes in the cycle after it
        chk("cycles", exp_cyc(op, r), 16'(n - 1));
        chk("busy", exp_cyc(op, r), 16'(b));
        chk("budget", exp_cyc(op, r), {11'h000, ccount});
        chk("length", exp_len(op), {14'h0000, blen});
        chk("mode", exp_mode(op), {13'h0000, smode});
        chk("flags", {8'h00, e_flags}, {8'h00, flags});
        chk("pointer", {8'h00, e_ptr}, {8'h00, ptr});
        chk("pc", e_pc, pc);
        $display("test op %h done", op);
    endtask
    task automatic results;
        $display("compared %0d, wrong %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        seed = 75;
        e_flags = 8'h00;
        e_ptr = 8'h00;
        e_pc = 16'h0000;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        run(8'ha2, 8'h02, 8'h03, 8'h00);
        run(8'hc2, 8'h02, 8'h02, 8'h7f);
        run(8'hc2, 8'h05, 8'h05, 8'h80);
        run(8'hc2, 8'h05, 8'h0a, 8'h10);
        run(8'ha6, 8'h80, 8'h01, 8'h00);
        for (i = 0; i < 40; i++) begin
            k = $unsigned($random(seed)) % 6;
            dst_value = 8'($random(seed));
            run(ops[k], dst_value, ($random(seed) & 1) ? dst_value
                : 8'($random(seed)), 8'($random(seed)));
        end
        // unknown opcode: pulse only, no state change
        @(negedge clk);
        opcode = 8'h00;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        chk("illegal", 16'h0001, {15'h0000, illegal});
        repeat (3) @(negedge clk);
        chk("flags kept", {8'h00, e_flags}, {8'h00, flags});
        chk("pc kept", e_pc, pc);
        results;
    end
    // watchdog well beyond the expected run time
    initial begin
        #400000;
        mismatches++;
        results;
    end
endmodule
`default_nettype wire
